// [logic/asop_serial_port.sv]
// Serial result output port with shared parallel pins, internal or external bit clock.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module asop_serial_port (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [17:0] convResult,
    input  wire logic        convBusy,
    input  wire logic        convDone,
    input  wire logic        parallelDataBit6In,
    output logic             parallelDataBit6Out,
    output logic             parallelDataBit6OeN,
    input  wire logic        parallelDataBit7In,
    output logic             parallelDataBit7Out,
    output logic             parallelDataBit7OeN,
    input  wire logic        parallelDataBit8In,
    output logic             parallelDataBit8Out,
    output logic             parallelDataBit8OeN,
    input  wire logic        parallelDataBit9In,
    output logic             parallelDataBit9Out,
    output logic             parallelDataBit9OeN,
    output logic             parallelDataBit10,
    input  wire logic        serialClkIn,
    output logic             serialClkOut,
    output logic             serialClkOeN,
    output logic             frameSyncOut
);
    typedef struct packed {
        asop_pkg::asop_state_t state;
        logic [1:0]            mode;
        logic [17:0]           result;
        logic [17:0]           shift;
        logic [17:0]           linkWord;
        logic [4:0]            bitCnt;
        logic [1:0]            divCnt;
        logic                  sclkLvl;
        logic                  busyDly;
        logic [3:0]            strap1;
        logic [3:0]            strap2;
        logic                  startTgl;
        logic [2:0]            doneSync;
        logic [31:0]           prdata;
        logic                  pslverr;
        logic                  pready;
        logic [3:0]            parOut;
        logic [3:0]            parOeN;
        logic                  bit10Out;
        logic                  sdoutM;
        logic                  selLink;
        logic                  sclkOut;
        logic                  sclkOeN;
        logic                  syncOut;
    } asop_port_st_t;

    asop_port_st_t r;
    asop_port_st_t n;

    logic        linkClk;
    logic        linkSdout;
    logic        doneTgl;
    logic        serial;
    logic        extClk;
    logic        syncPol;
    logic        clkInv;
    logic        rdcSel;
    logic        ctrlWrite;
    logic        startReq;
    logic        masterGo;
    logic [17:0] masterWord;

    assign serial  = (r.mode == asop_pkg::MODE_SERIAL);
    assign extClk  = r.strap2[asop_pkg::STRAP_EXT];
    assign syncPol = r.strap2[asop_pkg::STRAP_POL];
    assign clkInv  = r.strap2[asop_pkg::STRAP_INV];
    assign rdcSel  = r.strap2[asop_pkg::STRAP_RDC];

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    assign ctrlWrite  = psel && penable && pwrite && (paddr == asop_pkg::OFS_CTRL);
    assign startReq   = ctrlWrite && pwdata[asop_pkg::CTRL_START];
    // Read timing high starts on the rise of busy with the held result, low waits for done.
    assign masterGo   = rdcSel ? (convBusy && !r.busyDly) : convDone;
    assign masterWord = rdcSel ? r.result : convResult;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n          = r;
        n.busyDly  = convBusy;
        n.pready   = 1'b1;
        n.strap1   = {parallelDataBit9In, parallelDataBit8In, parallelDataBit7In, parallelDataBit6In};
        n.strap2   = r.strap1;
        n.doneSync = {r.doneSync[1:0], doneTgl};
        if (convDone) begin
            n.result = convResult;
        end

        // Answers are prepared in the setup phase so the access phase needs no wait.
        if (psel && !penable) begin
            n.prdata  = 32'h0000_0000;
            n.pslverr = 1'b0;
            case (paddr)
                asop_pkg::OFS_CTRL: begin
                    n.prdata[asop_pkg::CTRL_MODE_LSB +: 2] = r.mode;
                end
                asop_pkg::OFS_STATUS: begin
                    n.prdata[asop_pkg::STS_BUSY]          = (r.state != asop_pkg::ST_IDLE);
                    n.prdata[asop_pkg::STS_SERIAL]        = serial;
                    n.prdata[asop_pkg::STS_STRAP_LSB +: 4] = r.strap2;
                end
                asop_pkg::OFS_RESULT: begin
                    n.prdata[17:0] = r.result;
                end
                default: begin
                    n.pslverr = 1'b1;
                end
            endcase
            if (pwrite) begin
                n.prdata = 32'h0000_0000;
            end
        end
        if (ctrlWrite) begin
            n.mode = pwdata[asop_pkg::CTRL_MODE_LSB +: 2];
        end

        case (r.state)
            asop_pkg::ST_IDLE: begin
                if (serial && !extClk && masterGo) begin
                    n.state   = asop_pkg::ST_MASTER;
                    n.shift   = masterWord;
                    n.sdoutM  = masterWord[17];
                    n.bitCnt  = 5'h00;
                    n.divCnt  = 2'h0;
                    n.sclkLvl = 1'b0;
                end else if (serial && extClk && startReq) begin
                    n.state    = asop_pkg::ST_SLAVE;
                    n.linkWord = r.result;
                    n.startTgl = ~r.startTgl;
                end
            end
            asop_pkg::ST_MASTER: begin
                if (!serial) begin
                    n.state = asop_pkg::ST_IDLE;
                end else if (r.divCnt == asop_pkg::HALF_LAST) begin
                    n.divCnt  = 2'h0;
                    n.sclkLvl = ~r.sclkLvl;
                    if (r.sclkLvl) begin
                        if (r.bitCnt == asop_pkg::LAST_BIT) begin
                            n.state = asop_pkg::ST_IDLE;
                        end else begin
                            n.bitCnt = r.bitCnt + 5'h01;
                            n.shift  = {r.shift[16:0], 1'b0};
                            n.sdoutM = r.shift[16];
                        end
                    end
                end else begin
                    n.divCnt = r.divCnt + 2'h1;
                end
            end
            asop_pkg::ST_SLAVE: begin
                // A slave read ends only when the host has clocked all bits out.
                if (r.doneSync[2] != r.doneSync[1]) begin
                    n.state = asop_pkg::ST_IDLE;
                end
            end
            default: begin
                n.state = asop_pkg::ST_IDLE;
            end
        endcase

        // Pin multiplexing: parallel bits everywhere except serial mode.
        n.parOut   = r.result[9:6];
        n.parOeN   = serial ? 4'hF : 4'h0;
        n.bit10Out = r.result[10];
        n.selLink  = serial && extClk;
        if (!serial) begin
            n.sclkOut = r.result[11];
            n.sclkOeN = 1'b0;
            n.syncOut = r.result[12];
        end else if (extClk) begin
            n.sclkOut = 1'b0;
            n.sclkOeN = 1'b1;
            n.syncOut = syncPol;
        end else begin
            n.sclkOut = ((r.state == asop_pkg::ST_MASTER) && r.sclkLvl) ^ clkInv;
            n.sclkOeN = 1'b0;
            n.syncOut = (r.state == asop_pkg::ST_MASTER) ? ~syncPol : syncPol;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Host clock domain
    // ------------------------------------------------------------------
    // Inverting the clock swaps the update edge; the strap must be steady while
    // the host clocks, or the derived clock can glitch.
    assign linkClk = serialClkIn ^ clkInv;

    asop_link_shifter u_link (
        .linkClk       (linkClk),
        .sys_rst       (sys_rst),
        .startTgl      (r.startTgl),
        .word          (r.linkWord),
        .chainDataIn   (parallelDataBit9In),
        .serialDataOut (linkSdout),
        .doneTgl       (doneTgl)
    );

    assign prdata              = r.prdata;
    assign pready              = r.pready;
    assign pslverr             = r.pslverr;
    assign parallelDataBit6Out = r.parOut[0];
    assign parallelDataBit7Out = r.parOut[1];
    assign parallelDataBit8Out = r.parOut[2];
    assign parallelDataBit9Out = r.parOut[3];
    assign parallelDataBit6OeN = r.parOeN[0];
    assign parallelDataBit7OeN = r.parOeN[1];
    assign parallelDataBit8OeN = r.parOeN[2];
    assign parallelDataBit9OeN = r.parOeN[3];
    assign serialClkOut        = r.sclkOut;
    assign serialClkOeN        = r.sclkOeN;
    assign frameSyncOut        = r.syncOut;
    // In serial mode the data pin is a choice between two flip-flops, one per clock domain.
    assign parallelDataBit10   = !serial ? r.bit10Out : (r.selLink ? linkSdout : r.sdoutM);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_master_start;
        (r.state == asop_pkg::ST_IDLE) && serial && !extClk && masterGo;
    endsequence

    sequence s_sync_held;
        (frameSyncOut == ~syncPol) [*8];
    endsequence

    property p_parallel_pins;
        !serial |=> (parallelDataBit6OeN == 1'b0 && parallelDataBit9OeN == 1'b0 && r.bit10Out == $past(r.result[10]));
    endproperty
    a_parallel_pins: assert property (p_parallel_pins) else $error("Shared pins not parallel outside serial mode.");

    property p_master_drives;
        (serial && !extClk && $stable(r.mode)) |=> (serialClkOeN == 1'b0);
    endproperty
    a_master_drives: assert property (p_master_drives) else $error("Internal clock not driven out.");

    property p_slave_releases;
        (serial && extClk && $stable(r.mode)) |=> serialClkOeN;
    endproperty
    a_slave_releases: assert property (p_slave_releases) else $error("Clock pin driven in slave mode.");

    property p_sync_polarity;
        (r.state == asop_pkg::ST_IDLE && serial && !extClk && $stable(r.strap2)) |=> (frameSyncOut == $past(syncPol));
    endproperty
    a_sync_polarity: assert property (p_sync_polarity) else $error("Idle frame sync level wrong.");

    property p_clock_invert;
        (serial && !extClk && r.state == asop_pkg::ST_MASTER)
            |=> (serialClkOut == ($past(r.sclkLvl) ^ $past(clkInv)));
    endproperty
    a_clock_invert: assert property (p_clock_invert) else $error("Bit clock sense ignores invert strap.");

    property p_read_during;
        (s_master_start and rdcSel) |=> (r.shift == $past(r.result) && r.state == asop_pkg::ST_MASTER);
    endproperty
    a_read_during: assert property (p_read_during) else $error("Previous result not shifted during conversion.");

    property p_read_after;
        (r.state == asop_pkg::ST_IDLE && serial && !extClk && !rdcSel && !convDone) |=> (r.state != asop_pkg::ST_MASTER);
    endproperty
    a_read_after: assert property (p_read_after) else $error("Read began before conversion finished.");

    property p_msb_first;
        s_master_start |=> (r.sdoutM == $past(masterWord[17])) ##4 (r.sdoutM == $past(masterWord[16], 5));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Serial output not MSB first.");

    property p_sync_frame;
        (s_master_start and $stable(r.strap2)) |=> ##1 s_sync_held;
    endproperty
    a_sync_frame: assert property (p_sync_frame) else $error("Frame sync not held during read.");
endmodule

// [logic/asop_pkg.sv]
// Shared constants, register map and types of the converter serial output port.
package asop_pkg;
    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_STATUS    = 12'h004;
    localparam logic [11:0] OFS_RESULT    = 12'h008;
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_START    = 8;
    localparam logic [1:0]  CTRL_MODE_RST = 2'h0;
    localparam int          STS_BUSY      = 0;
    localparam int          STS_SERIAL    = 1;
    localparam int          STS_STRAP_LSB = 2;

    // ------------------------------------------------------------------
    // Interface modes and straps
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_SERIAL   = 2'h3;
    localparam int          STRAP_EXT     = 0;
    localparam int          STRAP_POL     = 1;
    localparam int          STRAP_INV     = 2;
    localparam int          STRAP_RDC     = 3;
    localparam int          RES_BITS      = 18;
    localparam logic [4:0]  LAST_BIT      = 5'h11;

    // ------------------------------------------------------------------
    // Timing of the internally generated bit clock
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          SCLK_HALF_NS  = 100;
    localparam int          HALF_CYC_INT  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  HALF_LAST     = 2'(HALF_CYC_INT - 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MASTER,
        ST_SLAVE
    } asop_state_t;
endpackage

// [logic/asop_link_shifter.sv]
// Shift register clocked by the host bit clock for external clock reads and chaining.
`timescale 1ns/1ps
module asop_link_shifter (
    input  wire logic        linkClk,
    input  wire logic        sys_rst,
    input  wire logic        startTgl,
    input  wire logic [17:0] word,
    input  wire logic        chainDataIn,
    output logic             serialDataOut,
    output logic             doneTgl
);
    typedef struct packed {
        logic        tgl1;
        logic        tgl2;
        logic        seen;
        logic [17:0] shift;
        logic [4:0]  cnt;
        logic        active;
        logic        done;
        logic        serial_data_out;
        logic [4:0]  since;
    } asop_link_st_t;

    asop_link_st_t r;
    asop_link_st_t n;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // The word is stable in the system domain until the done toggle returns,
    // so it is safe to take once the start toggle has been synchronised.
    always_comb begin
        n       = r;
        n.tgl1  = startTgl;
        n.tgl2  = r.tgl1;
        if (r.tgl2 != r.seen) begin
            n.seen   = r.tgl2;
            n.serial_data_out  = word[17];
            n.shift  = {word[16:0], chainDataIn};
            n.cnt    = 5'h00;
            n.active = 1'b1;
            n.since  = 5'h00;
        end else begin
            // Shifting goes on past the last own bit so that chained data follows.
            n.serial_data_out = r.shift[17];
            n.shift = {r.shift[16:0], chainDataIn};
            if (r.since != 5'h1F) begin
                n.since = r.since + 5'h01;
            end
            if (r.active) begin
                n.cnt = r.cnt + 5'h01;
                if (r.cnt == asop_pkg::LAST_BIT) begin
                    n.active = 1'b0;
                    n.done   = ~r.done;
                end
            end
        end
    end

    always_ff @(posedge linkClk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign serialDataOut = r.serial_data_out;
    assign doneTgl       = r.done;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_chain_delay;
        @(posedge linkClk) disable iff (sys_rst)
        (r.since >= 5'h12 && r.tgl2 == r.seen) |=> (serialDataOut == $past(chainDataIn, 19));
    endproperty
    a_chain_delay: assert property (p_chain_delay) else $error("Chain data not delayed by 18 clocks.");

    property p_first_bit;
        @(posedge linkClk) disable iff (sys_rst)
        (r.tgl2 != r.seen) |=> (serialDataOut == $past(word[17]) && r.active);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("Slave read did not start with the MSB.");
endmodule

// [tb/asop_host_model.sv]
// Host model that clocks external reads and feeds chained data.
`timescale 1ns/1ps
module asop_host_model (
    output logic             serialClk,
    output logic             chainData,
    input  wire logic        serialDataOut,
    input  wire logic        invert
);
    logic [63:0] pattern;
    logic [63:0] seen;
    int          upd;

    initial begin
        serialClk = 1'b0;
        chainData = 1'b0;
        upd = 0;
        seen = '0;
        pattern = 64'hC3A5_0F96_5A3C_E1D2;
    end

    // The clock stands low between frames; its phase is unrelated to the system clock.
    task automatic frame(input int edges);
        begin
            seen = '0;
            upd = 0;
            chainData = pattern[0];
            #3.3;
            repeat (edges) begin
                #7.5 serialClk = 1'b1;
                #7.5 serialClk = 1'b0;
            end
        end
    endtask

    // Data is taken on the edge after the update edge; chain data moves there too.
    always @(posedge serialClk or negedge serialClk) begin
        if (serialClk ^ invert) begin
            upd <= upd + 1;
        end else if (upd > 0 && upd < 64) begin
            seen[upd-1] <= serialDataOut;
            chainData <= pattern[upd];
        end
    end
endmodule

// [tb/asop_serial_port_tb.sv]
// Self-checking testbench of the converter serial output port.
`timescale 1ns/1ps
module asop_serial_port_tb;
    localparam logic [17:0] RES_A = 18'h2A5C3;
    localparam logic [17:0] RES_B = 18'h15A3C;
    localparam logic [17:0] RES_C = 18'h3C96D;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, convBusy, convDone, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic [17:0] convResult;
    logic [3:0]  strap, pOut, pOeN, pin;
    logic        parallelDataBit10, serialClkIn, serialClkOut, serialClkOeN, frameSyncOut, chainData;
    int          failures, comparisons, cycles;

    assign pin[0] = pOeN[0] ? strap[0] : pOut[0];
    assign pin[1] = pOeN[1] ? strap[1] : pOut[1];
    assign pin[2] = pOeN[2] ? strap[2] : pOut[2];
    assign pin[3] = pOeN[3] ? (strap[0] ? chainData : strap[3]) : pOut[3];

    asop_serial_port asop_serial_port_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convResult(convResult), .convBusy(convBusy), .convDone(convDone),
        .parallelDataBit6In(pin[0]), .parallelDataBit6Out(pOut[0]), .parallelDataBit6OeN(pOeN[0]),
        .parallelDataBit7In(pin[1]), .parallelDataBit7Out(pOut[1]), .parallelDataBit7OeN(pOeN[1]),
        .parallelDataBit8In(pin[2]), .parallelDataBit8Out(pOut[2]), .parallelDataBit8OeN(pOeN[2]),
        .parallelDataBit9In(pin[3]), .parallelDataBit9Out(pOut[3]), .parallelDataBit9OeN(pOeN[3]),
        .parallelDataBit10(parallelDataBit10), .serialClkIn(serialClkIn), .serialClkOut(serialClkOut),
        .serialClkOeN(serialClkOeN), .frameSyncOut(frameSyncOut));

    wire         serialClk_w;
    assign serialClkIn = serialClk_w;
    asop_host_model asop_host_model_i (
        .serialClk(serialClk_w), .chainData(chainData), .serialDataOut(parallelDataBit10), .invert(strap[2]));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Straps are changed only while the port is idle, then given time to settle.
    task automatic straps(input logic [3:0] s);
        @(posedge clk_sys);
        strap <= s;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic readMaster(input logic pol, input logic inv, input logic [17:0] exp);
        logic [17:0] got;
        logic        prev;
        int          n, b;
        got = '0;
        n = 0;
        b = 0;
        while (frameSyncOut !== ~pol && n < 20) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("syncActive", 32'(!pol), 32'(frameSyncOut));
        chk("clkDriven", 0, 32'(serialClkOeN));
        prev = serialClkOut ^ inv;
        while (b < 18 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
            if (!prev && (serialClkOut ^ inv)) begin
                got = {got[16:0], parallelDataBit10};
                b++;
                chk("syncHeld", 32'(!pol), 32'(frameSyncOut));
            end
            prev = serialClkOut ^ inv;
        end
        chk("masterWord", 32'(exp), 32'(got));
        repeat (8) @(posedge clk_sys);
        #1 chk("syncIdle", 32'(pol), 32'(frameSyncOut));
    endtask

    task automatic conclude();
        if (failures == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and test sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        {psel, penable, pwrite, convBusy, convDone, paddr, pwdata, convResult, strap} = '0;
        {failures, comparisons, cycles} = '0;
        sys_rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        convResult <= RES_A;
        convDone <= 1'b1;
        @(posedge clk_sys);
        convDone <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk("parallelPins", 32'(RES_A[12:6]), 32'({frameSyncOut, serialClkOut, parallelDataBit10, pOut}));
        chk("parallelOeN", 0, 32'(pOeN));
        apb(1'b0, asop_pkg::OFS_RESULT, 0);
        chk("result", 32'(RES_A), rdData);
        apb(1'b0, 12'h00C, 0);
        chk("unmappedErr", 1, 32'(rdErr));
        apb(1'b1, asop_pkg::OFS_STATUS, 32'hFFFFFFFF);
        apb(1'b0, asop_pkg::OFS_CTRL, 0);
        chk("ctrlReset", 0, rdData);
        apb(1'b1, asop_pkg::OFS_CTRL, 32'h00000003);
        repeat (3) @(posedge clk_sys);
        #1 chk("serialOeN", 32'hF, 32'(pOeN));
        straps(4'hE);
        convBusy <= 1'b1;
        fork
            readMaster(1'b1, 1'b1, RES_A);
            begin
                repeat (30) @(posedge clk_sys);
                convResult <= RES_B;
                convDone <= 1'b1;
                @(posedge clk_sys);
                convDone <= 1'b0;
                convBusy <= 1'b0;
            end
        join
        straps(4'h0);
        convBusy <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1 chk("noEarlyFrame", 0, 32'(frameSyncOut));
        @(posedge clk_sys);
        convResult <= RES_C;
        convDone <= 1'b1;
        convBusy <= 1'b0;
        @(posedge clk_sys);
        convDone <= 1'b0;
        readMaster(1'b0, 1'b0, RES_C);
        for (int inv = 0; inv < 2; inv++) begin
            straps({1'b0, inv[0], 2'b01});
            #1 chk("clkInput", 1, 32'(serialClkOeN));
            apb(1'b1, asop_pkg::OFS_CTRL, 32'h00000103);
            apb(1'b0, asop_pkg::OFS_STATUS, 0);
            chk("slaveBusy", 32'h7, 32'(rdData[2:0]));
            asop_host_model_i.frame(28);
            repeat (10) @(posedge clk_sys);
            // The host stores bits in arrival order, so the MSB sits at index 2, after two synchroniser clocks.
            for (int k = 0; k < 18; k++) begin
                chk("slaveWord", 32'(RES_C[17-k]), 32'(asop_host_model_i.seen[2+k]));
            end
            for (int j = 0; j < 6; j++) begin
                chk("chainBit", 32'(asop_host_model_i.pattern[2+j]), 32'(asop_host_model_i.seen[20+j]));
            end
            apb(1'b0, asop_pkg::OFS_STATUS, 0);
            chk("slaveIdle", 0, 32'(rdData[0]));
        end
        conclude();
    end
endmodule
